//--- hw/pmc_pkg.sv
package pmc_pkg;
  localparam logic [5:0] OFS_RESERVED_CONTROL = 6'h00;
  localparam logic [5:0] OFS_SLEEP_CONFIG = 6'h01;
  localparam logic [5:0] OFS_PROCESSOR_CLOCK_DIVIDER = 6'h08;
  localparam logic [5:0] OFS_BUS_A_DIVIDER = 6'h09;
  localparam logic [5:0] OFS_BUS_B_DIVIDER = 6'h0A;
  localparam logic [5:0] OFS_BUS_C_DIVIDER = 6'h0B;
  localparam logic [5:0] OFS_HIGHSPEED_BUS_CLOCK_GATES = 6'h14;
  localparam logic [5:0] OFS_BUS_A_CLOCK_GATES = 6'h18;
  localparam logic [5:0] OFS_BUS_B_CLOCK_GATES = 6'h1C;
  localparam logic [5:0] OFS_BUS_C_CLOCK_GATES = 6'h20;
  localparam logic [5:0] OFS_IRQ_ENABLE_CLEAR = 6'h34;
  localparam logic [5:0] OFS_IRQ_ENABLE_SET = 6'h35;
  localparam logic [5:0] OFS_IRQ_FLAGS = 6'h36;
  localparam logic [5:0] OFS_LAST_RESET_SOURCE = 6'h38;
  localparam logic [1:0] IDLE_FIELD_MASK = 2'h3;
  localparam logic [2:0] PRESCALE_FIELD_MASK = 3'h7;
  localparam logic [31:0] HSB_GATES_MASK = 32'h0000007F;
  localparam logic [31:0] HSB_GATES_RESET = 32'h0000007F;
  localparam logic [31:0] BUS_A_GATES_MASK = 32'h0000007F;
  localparam logic [31:0] BUS_A_GATES_RESET = 32'h0000007F;
  localparam logic [31:0] BUS_B_GATES_MASK = 32'h0000007F;
  localparam logic [31:0] BUS_B_GATES_RESET = 32'h0000007F;
  localparam logic [31:0] BUS_C_GATES_MASK = 32'h001FFFFF;
  localparam logic [31:0] BUS_C_GATES_RESET = 32'h00010000;
  localparam int CLOCK_READY_BIT = 0;
  localparam logic [1:0] IDLE_PROCESSOR = 2'h0;
  localparam logic [1:0] IDLE_HIGHSPEED = 2'h1;
  localparam logic [1:0] IDLE_PERIPHERAL = 2'h2;

  typedef struct packed {
    logic processor;
    logic highspeed;
    logic peripheral;
  } pmc_halt_t;

  typedef struct packed {
    logic [5:0] addr;
    logic [3:0] byteEn;
    logic [31:0] wdata;
    logic write;
    logic read;
  } pmc_req_t;
endpackage

//--- hw/pmc_prescaler.sv
`timescale 1ns/10ps
`default_nettype none
// Power-of-two enable divider; ratio changes only at a period boundary
module pmc_prescaler #(
  parameter int SEL_WIDTH = 3
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic run,
  input wire logic [SEL_WIDTH-1:0] select,
  output logic tick
);
  localparam int CW = (1 << SEL_WIDTH) - 1;
  logic [CW-1:0] count;
  logic [SEL_WIDTH-1:0] active;
  logic [CW-1:0] limit;

  always_comb
  begin
    limit = CW'((1 << active) - 1);
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      count <= '0;
      active <= '0;
      tick <= 1'b0;
    end
    else if (run)
    begin
      tick <= (count >= limit);
      if (count >= limit)
      begin
        count <= '0;
        // R13 boundary-only switch
        active <= select;
      end
      else
      begin
        count <= count + CW'(1);
      end
    end
    else
    begin
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- hw/pmc_byte_lanes.sv
`timescale 1ns/10ps
`default_nettype none
// Byte-lane merge of a write into a register word
module pmc_byte_lanes (
  input wire logic [31:0] current,
  input wire logic [31:0] wdata,
  input wire logic [3:0] byteEn,
  input wire logic [31:0] writable,
  output logic [31:0] merged
);
  always_comb
  begin
    merged = current;
    for (int i = 0; i < 4; i++)
    begin
      if (byteEn[i])
      begin
        merged[i*8 +: 8] = wdata[i*8 +: 8];
      end
    end
    merged = merged & writable;
  end
endmodule
`default_nettype wire

//--- hw/pmc_regs.sv
// Operation
// R1 - Byte, half and word accesses, including direct byte and half lanes.
// R2 - Software touches the bus divider registers only with byte transfers.
// R3 - Protected registers ignore writes while protection is on.
// R4 - Reserved bits always read zero.
// R5 - Software writes zero into reserved bit positions.
// R6 - Idle field selects which domains halt on wait-for-interrupt.
// R7 - Idle 0 processor, 1 adds high-speed bus, 2 adds peripheral.
// R8 - Processor prescaler divides main clock by two to the field.
// R9 - Control register at zero is reserved, reads zero.
// R10 - Each bus prescaler divides by two to the field value.
// R11 - Clock gate bit zero stops, one enables module clock.
// R12 - Ready flag set by event, write-one clear; enable set/clear; request.
// R13 - Prescaler change causes no shortened divided clock pulse.
`timescale 1ns/10ps
`default_nettype none
module pmc_regs (
  input wire logic clk,
  input wire logic reset,
  input wire pmc_pkg::pmc_req_t req,
  input wire logic writeProtect,
  input wire logic waitForInterrupt,
  input wire logic wakeUp,
  input wire logic clockReadyEvent,
  input wire logic [7:0] resetCause,
  output logic [31:0] rdata,
  output logic processorTick,
  output logic busATick,
  output logic busBTick,
  output logic busCTick,
  output pmc_pkg::pmc_halt_t halt,
  output logic [31:0] highspeedGates,
  output logic [31:0] busAGates,
  output logic [31:0] busBGates,
  output logic [31:0] busCGates,
  output logic irqRequest
);
  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_SLEEP = 2'b10
  } pmc_state_t;

  pmc_state_t state;
  logic [1:0] idleMode;
  logic [2:0] procSel, busASel, busBSel, busCSel;
  logic clockReadyFlag, clockReadyEnable;
  logic [7:0] resetSource;
  logic [31:0] mHsb, mA, mB, mC;
  logic wrOk;

  // Word offset and lane within it
  function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
    hit = (a[5:2] == ofs[5:2]);
  endfunction

  function automatic logic [7:0] lane(input logic [31:0] d,
                                      input logic [1:0] l);
    lane = d[l*8 +: 8];
  endfunction

  // R3 protect gate
  assign wrOk = req.write && !writeProtect;

  // R1 lane merge
  pmc_byte_lanes uHsb (.current(highspeedGates), .wdata(req.wdata),
    .byteEn(req.byteEn), .writable(pmc_pkg::HSB_GATES_MASK), .merged(mHsb));
  pmc_byte_lanes uA (.current(busAGates), .wdata(req.wdata),
    .byteEn(req.byteEn), .writable(pmc_pkg::BUS_A_GATES_MASK), .merged(mA));
  pmc_byte_lanes uB (.current(busBGates), .wdata(req.wdata),
    .byteEn(req.byteEn), .writable(pmc_pkg::BUS_B_GATES_MASK), .merged(mB));
  pmc_byte_lanes uC (.current(busCGates), .wdata(req.wdata),
    .byteEn(req.byteEn), .writable(pmc_pkg::BUS_C_GATES_MASK), .merged(mC));

  // Byte registers in word 0 and word 2
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      idleMode <= 2'h0;
      procSel <= 3'h0;
      busASel <= 3'h0;
      busBSel <= 3'h0;
      busCSel <= 3'h0;
    end
    else if (wrOk)
    begin
      // R6 idle field store
      if (hit(req.addr, pmc_pkg::OFS_SLEEP_CONFIG) && req.byteEn[1])
      begin
        idleMode <= 2'(lane(req.wdata, 2'h1)) & pmc_pkg::IDLE_FIELD_MASK;
      end
      if (hit(req.addr, pmc_pkg::OFS_PROCESSOR_CLOCK_DIVIDER))
      begin
        // R8 processor prescale field
        if (req.byteEn[0])
        begin
          procSel <= 3'(lane(req.wdata, 2'h0)) & pmc_pkg::PRESCALE_FIELD_MASK;
        end
        // R10 bus prescale fields
        if (req.byteEn[1])
        begin
          busASel <= 3'(lane(req.wdata, 2'h1)) & pmc_pkg::PRESCALE_FIELD_MASK;
        end
        if (req.byteEn[2])
        begin
          busBSel <= 3'(lane(req.wdata, 2'h2)) & pmc_pkg::PRESCALE_FIELD_MASK;
        end
        if (req.byteEn[3])
        begin
          busCSel <= 3'(lane(req.wdata, 2'h3)) & pmc_pkg::PRESCALE_FIELD_MASK;
        end
      end
    end
  end

  // Clock gate masks
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      highspeedGates <= pmc_pkg::HSB_GATES_RESET;
      busAGates <= pmc_pkg::BUS_A_GATES_RESET;
      busBGates <= pmc_pkg::BUS_B_GATES_RESET;
      busCGates <= pmc_pkg::BUS_C_GATES_RESET;
    end
    else if (wrOk)
    begin
      // R11 gate mask writes
      if (hit(req.addr, pmc_pkg::OFS_HIGHSPEED_BUS_CLOCK_GATES))
      begin
        highspeedGates <= mHsb;
      end
      if (hit(req.addr, pmc_pkg::OFS_BUS_A_CLOCK_GATES))
      begin
        busAGates <= mA;
      end
      if (hit(req.addr, pmc_pkg::OFS_BUS_B_CLOCK_GATES))
      begin
        busBGates <= mB;
      end
      if (hit(req.addr, pmc_pkg::OFS_BUS_C_CLOCK_GATES))
      begin
        busCGates <= mC;
      end
    end
  end

  // Interrupt flag and enable; not write-protected
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      clockReadyFlag <= 1'b0;
      clockReadyEnable <= 1'b0;
      irqRequest <= 1'b0;
    end
    else
    begin
      // R12 set wins over clear
      if (clockReadyEvent)
      begin
        clockReadyFlag <= 1'b1;
      end
      else if (req.write && hit(req.addr, pmc_pkg::OFS_IRQ_FLAGS)
               && req.byteEn[2] && req.wdata[16 + pmc_pkg::CLOCK_READY_BIT])
      begin
        clockReadyFlag <= 1'b0;
      end
      if (req.write && hit(req.addr, pmc_pkg::OFS_IRQ_ENABLE_SET)
          && req.byteEn[1] && req.wdata[8 + pmc_pkg::CLOCK_READY_BIT])
      begin
        clockReadyEnable <= 1'b1;
      end
      else if (req.write && hit(req.addr, pmc_pkg::OFS_IRQ_ENABLE_CLEAR)
               && req.byteEn[0] && req.wdata[pmc_pkg::CLOCK_READY_BIT])
      begin
        clockReadyEnable <= 1'b0;
      end
      // R12 request level
      irqRequest <= clockReadyFlag && clockReadyEnable;
    end
  end

  // Reset cause captured after reset release
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      resetSource <= 8'h00;
    end
    else if (state == ST_RUN && resetSource == 8'h00)
    begin
      resetSource <= resetCause;
    end
  end

  // Sleep state: halt per idle level
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state <= ST_RUN;
      halt <= '0;
    end
    else
    begin
      case (state)
        ST_RUN:
        begin
          if (waitForInterrupt)
          begin
            state <= ST_SLEEP;
            // R7 idle level encoding
            halt.processor <= 1'b1;
            halt.highspeed <= (idleMode == pmc_pkg::IDLE_HIGHSPEED)
                           || (idleMode == pmc_pkg::IDLE_PERIPHERAL);
            halt.peripheral <= (idleMode == pmc_pkg::IDLE_PERIPHERAL);
          end
        end
        ST_SLEEP:
        begin
          if (wakeUp)
          begin
            state <= ST_RUN;
            halt <= '0;
          end
        end
        default:
        begin
          state <= ST_RUN;
          halt <= '0;
        end
      endcase
    end
  end

  // R8 processor divider
  pmc_prescaler #(.SEL_WIDTH(3)) uProc (.clk(clk), .reset(reset),
    .run(1'b1), .select(procSel), .tick(processorTick));
  // R10 bus dividers
  pmc_prescaler #(.SEL_WIDTH(3)) uBusA (.clk(clk), .reset(reset),
    .run(1'b1), .select(busASel), .tick(busATick));
  pmc_prescaler #(.SEL_WIDTH(3)) uBusB (.clk(clk), .reset(reset),
    .run(1'b1), .select(busBSel), .tick(busBTick));
  pmc_prescaler #(.SEL_WIDTH(3)) uBusC (.clk(clk), .reset(reset),
    .run(1'b1), .select(busCSel), .tick(busCTick));

  // Read data, registered; R4 and R9 reserved bits zero
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rdata <= 32'h00000000;
    end
    else if (req.read)
    begin
      rdata <= 32'h00000000;
      case (req.addr[5:2])
        4'h0:
        begin
          rdata <= {22'h000000, idleMode, 8'h00};
        end
        4'h2:
        begin
          rdata <= {5'h00, busCSel, 5'h00, busBSel, 5'h00, busASel,
                    5'h00, procSel};
        end
        4'h5:
        begin
          rdata <= highspeedGates;
        end
        4'h6:
        begin
          rdata <= busAGates;
        end
        4'h7:
        begin
          rdata <= busBGates;
        end
        4'h8:
        begin
          rdata <= busCGates;
        end
        4'hD:
        begin
          // Lane 0 and lane 1 show the enable, lane 2 the flag
          rdata <= {8'h00, 7'h00, clockReadyFlag, 7'h00, clockReadyEnable,
                    7'h00, clockReadyEnable};
        end
        4'hE:
        begin
          rdata <= {24'h000000, resetSource};
        end
        default:
        begin
          rdata <= 32'h00000000;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

//--- testbench/pmc_regs_props.sv
`timescale 1ns/10ps
`default_nettype none
module pmc_regs_props (
  input wire logic clk,
  input wire logic reset,
  input wire pmc_pkg::pmc_req_t req,
  input wire logic writeProtect,
  input wire logic waitForInterrupt,
  input wire logic wakeUp,
  input wire logic clockReadyEvent,
  input wire logic [31:0] rdata,
  input wire pmc_pkg::pmc_halt_t halt,
  input wire logic [31:0] busAGates,
  input wire logic irqRequest
);
  logic rd;
  logic [3:0] w;
  assign rd = req.read;
  assign w = req.addr[5:2];
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  gates_reset_a: assert property ($past(reset) |->
    busAGates == 32'h0000007F) else $error("gates not at reset value");
  gates_rsvd_a: assert property ((busAGates & 32'hFFFFFF80) == 32'h0)
    else $error("reserved gate bit set");
  protect_hold_a: assert property (req.write && writeProtect |=>
    $stable(busAGates)) else $error("protected write took effect");
  ctrl_zero_a: assert property (rd && w == 4'h0 |=>
    (rdata & 32'hFFFFFCFF) == 32'h0) else $error("control word not zero");
  div_rsvd_a: assert property (rd && w == 4'h2 |=>
    (rdata & 32'hF8F8F8F8) == 32'h0) else $error("divider spare bit set");
  unmapped_zero_a: assert property (rd && w > 4'h8 && w < 4'hD |=>
    rdata == 32'h0) else $error("unmapped read not zero");
  sleep_enter_a: assert property (waitForInterrupt && !wakeUp |=>
    halt.processor) else $error("no halt after wait");
  halt_nest_a: assert property ((!halt.peripheral || halt.highspeed) &&
    (!halt.highspeed || halt.processor)) else $error("halt levels disordered");
  enable_clear_a: assert property (req.write && w == 4'hD &&
    req.byteEn[0] && req.wdata[0] && !(req.byteEn[1] && req.wdata[8])
    |=> ##1 !irqRequest) else $error("request kept after disable");
  flag_clear_a: assert property (req.write && w == 4'hD &&
    req.byteEn[2] && req.wdata[16] && !clockReadyEvent
    |=> ##1 !irqRequest) else $error("request kept after flag clear");
endmodule
bind pmc_regs pmc_regs_props u_props (.clk(clk), .reset(reset), .req(req),
  .writeProtect(writeProtect), .waitForInterrupt(waitForInterrupt),
  .wakeUp(wakeUp), .clockReadyEvent(clockReadyEvent), .rdata(rdata),
  .halt(halt), .busAGates(busAGates), .irqRequest(irqRequest));
`default_nettype wire

//--- testbench/pmc_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
module pmc_cpu_model (
  input wire logic clk,
  input wire logic [31:0] rdata,
  output var pmc_pkg::pmc_req_t req
);
  initial req = '0;
  task automatic access(logic w, logic [5:0] a, logic [3:0] be,
    logic [31:0] v, output logic [31:0] rd);
    @(negedge clk);
    // lanes and data exactly as the caller shaped them
    req = '{a, be, v, w, !w};
    @(negedge clk);
    rd = rdata;
    req = '{~a, 4'h0, ~v, 1'b0, 1'b0};
  endtask
endmodule
`default_nettype wire

//--- testbench/tb_pmc_regs.sv
`timescale 1ns/10ps
`default_nettype none
module tb_pmc_regs;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic writeProtect = 1'b0;
  logic waitForInterrupt = 1'b0;
  logic wakeUp = 1'b0;
  logic clockReadyEvent = 1'b0;
  logic [7:0] resetCause = 8'h40;
  logic [15:0] seed = 16'h1C24;
  pmc_pkg::pmc_req_t req;
  pmc_pkg::pmc_halt_t halt;
  logic [31:0] rdata, rd, d, e;
  logic [31:0] gates [4];
  logic [3:0] ticks;
  logic irqRequest;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;
  always #25 clk = ~clk;
  pmc_cpu_model cpu (.clk(clk), .rdata(rdata), .req(req));
  pmc_regs DUT (.clk(clk), .reset(reset), .req(req),
    .writeProtect(writeProtect), .waitForInterrupt(waitForInterrupt),
    .wakeUp(wakeUp), .clockReadyEvent(clockReadyEvent),
    .resetCause(resetCause), .rdata(rdata), .processorTick(ticks[0]),
    .busATick(ticks[1]), .busBTick(ticks[2]), .busCTick(ticks[3]),
    .halt(halt), .highspeedGates(gates[0]), .busAGates(gates[1]),
    .busBGates(gates[2]), .busCGates(gates[3]), .irqRequest(irqRequest));
  function automatic logic [31:0] lfsr();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return {seed, ~seed};
  endfunction
  function automatic logic [31:0] lanes(logic [3:0] be);
    return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction
  function automatic logic [2:0] halt_of(int l);
    return {1'b1, l > 0, l > 1};
  endfunction
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [5:0] a, logic [3:0] be, logic [31:0] v);
    cpu.access(1'b1, a, be, v, rd);
  endtask
  task automatic rdc(logic [5:0] a, logic [3:0] be, logic [31:0] exp);
    cpu.access(1'b0, a, be, 32'h0, rd);
    check("read data", exp, rd & lanes(be));
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask
  // Skips the period in flight and one full period, then times the next one
  task automatic period(int i, int exp);
    int n;
    repeat (3)
    begin
      n = 0;
      do
      begin
        @(negedge clk);
        n++;
      end
      while (ticks[i] !== 1'b1 && n < 300);
    end
    check("tick period", exp, n);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      stop_test();
    end
  end
  initial
  begin
    repeat (4) @(negedge clk);
    reset = 1'b0;
    rdc(6'h00, 4'hF, 32'h0);
    rdc(6'h14, 4'hF, 32'h7F);
    check("gates C", pmc_pkg::BUS_C_GATES_RESET, gates[3]);
    check("gates A", pmc_pkg::BUS_A_GATES_RESET, gates[1]);
    check("gates B", pmc_pkg::BUS_B_GATES_RESET, gates[2]);
    wr(6'h38, 4'h1, 32'h77);
    rdc(6'h38, 4'h1, 32'h40);
    $display("reset values done");
    for (int r = 0; r < 2; r++)
      for (int i = 0; i < 4; i++)
      begin
        d = (r == 0 && i == 0) ? 32'h7 : lfsr() & 32'h7;
        wr(6'h08 + 6'(i), 4'h1 << i, d << 8 * i);
        rdc(6'h08 + 6'(i), 4'h1 << i, d << 8 * i);
        period(i, 1 << d[2:0]);
      end
    $display("prescalers done");
    e = lfsr() & pmc_pkg::BUS_C_GATES_MASK;
    wr(6'h20, 4'hF, e);
    check("gates C", e, gates[3]);
    wr(6'h22, 4'hC, 32'h0);
    wr(6'h21, 4'h2, 32'hFF00);
    e = (e & 32'hFFFF) | 32'hFF00;
    rdc(6'h20, 4'hF, e);
    wr(6'h18, 4'h1, 32'h55);
    check("gates A", 32'h55, gates[1]);
    $display("gate lanes done");
    writeProtect = 1'b1;
    wr(6'h20, 4'hF, 32'h0);
    wr(6'h01, 4'h2, 32'h200);
    check("gates C", e, gates[3]);
    wr(6'h18, 4'hF, 32'h0);
    check("gates A", 32'h55, gates[1]);
    rdc(6'h00, 4'hF, 32'h0);
    writeProtect = 1'b0;
    $display("protection done");
    for (int l = 0; l < 3; l++)
    begin
      wr(6'h01, 4'h2, 32'(l) << 8);
      rdc(6'h00, 4'hF, 32'(l) << 8);
      pulse(waitForInterrupt);
      check("halt", 32'(halt_of(l)), 32'(halt));
      pulse(wakeUp);
      check("halt", 32'h0, 32'(halt));
    end
    $display("sleep done");
    pulse(clockReadyEvent);
    rdc(6'h34, 4'hF, 32'h10000);
    check("request", 32'h0, 32'(irqRequest));
    wr(6'h35, 4'h2, 32'h100);
    @(negedge clk);
    check("request", 32'h1, 32'(irqRequest));
    wr(6'h34, 4'h1, 32'h1);
    @(negedge clk);
    check("request", 32'h0, 32'(irqRequest));
    wr(6'h35, 4'h2, 32'h100);
    wr(6'h36, 4'h4, 32'h10000);
    @(negedge clk);
    check("request", 32'h0, 32'(irqRequest));
    rdc(6'h34, 4'hF, 32'h101);
    rdc(6'h24, 4'hF, 32'h0);
    rdc(6'h30, 4'hF, 32'h0);
    $display("interrupt and unmapped done");
    stop_test();
  end
endmodule
`default_nettype wire
